// File: hdl/xcbt_top.sv
// Board test chain logic with strap capture and video code entry.
// Functional notes
// (R1) Each gate takes pin and previous gate output.
// (R2) First gate seeded with logic high.
// (R3) Last gate drives chain output pin.
// (R4) Eight independent chains, under 65 gates.
// (R5) Even ones give 1, odd give 0.
// (R6) Chain bidirectional pins act as inputs only.
// (R7) Tester drives paired strobes complementary.
// (R8) Row strobe low across reset enters chains 1-6; the code enters chains 1-4 only, with chains 5-6 tied low.
// (R9) Tester keeps reset high while testing.
// (R10) Address bit 2 low across reset: chains 7-8.
// (R11) Tester presents first video code with clock pulse.
// (R12) Tester presents second video code with clock pulse.
// (R13) Chain outputs follow pins without clock.
// (R14) Tester walks ones, expects alternating output.
// (R15) Gates in pin buffers; entry by straps only.
// (R16) Chain 1: 35 inputs onto address bit 5.
// (R17) Chain 2: 33 inputs onto address bit 2.
// (R18) Chain 3: 38 inputs onto address bit 0.
// (R19) Chain 4: 36 inputs onto address bit 9.
// (R20) Chains 7-8 armed after both codes in order.
// (R21) Straps sampled at reset release, held until reset.
`timescale 1ns/1ps
`default_nettype none
module xcbt_top
	import xcbt_pkg::*;
#(
	parameter int CH1_LEN = XCBT_CH1_LEN,
	parameter int CH2_LEN = XCBT_CH2_LEN,
	parameter int CH3_LEN = XCBT_CH3_LEN,
	parameter int CH4_LEN = XCBT_CH4_LEN,
	parameter int CH7_LEN = XCBT_CH7_LEN,
	parameter int CH8_LEN = XCBT_CH8_LEN
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic mem_row_strobe_pin_in,
	input wire logic mem_addr_bit2_pin_in,
	input wire logic video_port_clock_pin_in,
	input wire logic [5:0] video_port_data_pins_in,
	input wire logic [CH1_LEN-1:0] chain1_pins_in,
	input wire logic [CH2_LEN-1:0] chain2_pins_in,
	input wire logic [CH3_LEN-1:0] chain3_pins_in,
	input wire logic [CH4_LEN-1:0] chain4_pins_in,
	input wire logic [CH7_LEN-1:0] chain7_pins_in,
	input wire logic [CH8_LEN-1:0] chain8_pins_in,
	input wire logic [3:0] func_addr_out_in,
	output logic [3:0] chain_pins_oe_out,
	output logic test_low_mode_out,
	output logic test_high_mode_out,
	output logic mem_addr_bit5_pin_out,
	output logic mem_addr_bit2_pin_out,
	output logic mem_addr_bit0_pin_out,
	output logic mem_addr_bit9_pin_out,
	output logic mem_addr_bit8_pin_out,
	output logic mem_addr_bit4_pin_out
);
	xcbt_chain_if ch ();
	xcbt_state_t state_q, state_d;
	logic low_mode_q, low_mode_d;
	logic armed_q;
	logic strap_taken_q;
	logic vclk_q;
	logic [3:0] oe_q;
	logic [3:0] func_q;
	logic vclk_rise;
	logic code1_hit, code2_hit;

	// Place each chain's pins in the low slots; unused slots stay low.
	assign ch.pins[0] = {{(XCBT_MAX_GATES-CH1_LEN){1'h0}}, chain1_pins_in};
	assign ch.pins[1] = {{(XCBT_MAX_GATES-CH2_LEN){1'h0}}, chain2_pins_in};
	assign ch.pins[2] = {{(XCBT_MAX_GATES-CH3_LEN){1'h0}}, chain3_pins_in};
	assign ch.pins[3] = {{(XCBT_MAX_GATES-CH4_LEN){1'h0}}, chain4_pins_in};
	assign ch.pins[4] = '0;
	assign ch.pins[5] = '0;
	assign ch.pins[6] = {{(XCBT_MAX_GATES-CH7_LEN){1'h0}}, chain7_pins_in};
	assign ch.pins[7] = {{(XCBT_MAX_GATES-CH8_LEN){1'h0}}, chain8_pins_in};

	xcbt_tree u_tree (
		.ch(ch)
	);

	// Video code decode, each code taken as the video clock rises.
	assign vclk_rise = video_port_clock_pin_in & ~vclk_q;
	assign code1_hit = vclk_rise & (video_port_data_pins_in == XCBT_CODE_FIRST);
	assign code2_hit = vclk_rise &
		(video_port_data_pins_in == XCBT_CODE_SECOND);

	// Entry sequencer; a wrong code other than the first sends it back to wait for the first.
	always_comb begin
		state_d = state_q;
		case (state_q)
			XCBT_IDLE: begin
				state_d = XCBT_IDLE;
			end
			XCBT_WAIT1: begin
				if (code1_hit) begin
					state_d = XCBT_WAIT2; // [R20]
				end
			end
			XCBT_WAIT2: begin
				if (code2_hit) begin
					state_d = XCBT_ARMED; // [R20]
				end else if (vclk_rise && !code1_hit) begin
					state_d = XCBT_WAIT1;
				end
			end
			XCBT_ARMED: begin
				state_d = XCBT_ARMED;
			end
			default: begin
				state_d = XCBT_IDLE;
			end
		endcase
		// Straps are looked at once, on the first edge after reset release.
		if (!strap_taken_q) begin
			state_d = mem_addr_bit2_pin_in ? XCBT_IDLE : XCBT_WAIT1; // [R10] [R21]
		end
	end

	// The row strobe strap is caught once and held until the next reset.
	assign low_mode_d = strap_taken_q ? low_mode_q :
		~mem_row_strobe_pin_in; // [R8] [R21]

	// Mode state; reset loads constants only, the straps come in afterward.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= XCBT_IDLE;
			low_mode_q <= 1'h0;
			strap_taken_q <= 1'h0;
			vclk_q <= 1'h0;
			armed_q <= 1'h0;
		end else begin
			state_q <= state_d;
			low_mode_q <= low_mode_d;
			strap_taken_q <= 1'h1; // [R15]
			vclk_q <= video_port_clock_pin_in;
			armed_q <= (state_d == XCBT_ARMED);
		end
	end

	// Mode-side registers. The chain results are not retimed: a board
	// tester may apply vectors with the clock stopped, so the result pins
	// must follow the chain pins. Only the mode select and the functional
	// value behind the output mux come from flops.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			func_q <= '0;
			oe_q <= '0;
		end else begin
			func_q <= func_addr_out_in;
			oe_q <= {4{~low_mode_d}}; // [R6]
		end
	end

	// Chain pins are inputs while the low mode is active, and from reset until the straps are taken.
	assign chain_pins_oe_out = oe_q; // [R6]
	assign test_low_mode_out = low_mode_q;
	assign test_high_mode_out = armed_q;

	// Result pins follow the clockless tree while a mode is latched.
	assign mem_addr_bit5_pin_out = low_mode_q ? ch.result[0] :
		func_q[0]; // [R3] [R13] [R16]
	assign mem_addr_bit2_pin_out = low_mode_q ? ch.result[1] :
		func_q[1]; // [R17]
	assign mem_addr_bit0_pin_out = low_mode_q ? ch.result[2] :
		func_q[2]; // [R18]
	assign mem_addr_bit9_pin_out = low_mode_q ? ch.result[3] :
		func_q[3]; // [R19]
	assign mem_addr_bit8_pin_out = armed_q & ch.result[6]; // [R13]
	assign mem_addr_bit4_pin_out = armed_q & ch.result[7]; // [R13]

	// Chain checks; the expected result levels come from the pin parity, the enable and idle levels from the modes.
	a_chain_parity: assert property ( // [R5]
		@(posedge clk_in) disable iff (!rst_n_in)
		low_mode_q |-> mem_addr_bit5_pin_out == ~(^chain1_pins_in))
		else $error("chain one parity wrong");
	a_chain_seed: assert property ( // [R2]
		@(posedge clk_in) disable iff (!rst_n_in)
		low_mode_q && (chain2_pins_in == '0) |-> mem_addr_bit2_pin_out)
		else $error("chain two seed wrong");
	a_out_select: assert property ( // [R3]
		@(posedge clk_in) disable iff (!rst_n_in)
		low_mode_q |-> mem_addr_bit0_pin_out == ~(^chain3_pins_in))
		else $error("chain three not on output");
	a_chain_four: assert property ( // [R19]
		@(posedge clk_in) disable iff (!rst_n_in)
		low_mode_q |-> mem_addr_bit9_pin_out == ~(^chain4_pins_in))
		else $error("chain four parity wrong");
	a_high_parity: assert property ( // [R13]
		@(posedge clk_in) disable iff (!rst_n_in)
		armed_q |-> mem_addr_bit8_pin_out == ~(^chain7_pins_in) &&
			mem_addr_bit4_pin_out == ~(^chain8_pins_in))
		else $error("high chain parity wrong");
	a_high_gate: assert property ( // [R20]
		@(posedge clk_in) disable iff (!rst_n_in)
		!armed_q |-> !mem_addr_bit8_pin_out && !mem_addr_bit4_pin_out)
		else $error("high chain output while not armed");
	a_oe_off: assert property ( // [R6]
		@(posedge clk_in) disable iff (!rst_n_in)
		low_mode_q && $past(low_mode_q) |-> chain_pins_oe_out == 4'h0)
		else $error("chain pin driven in test");
	a_oe_on: assert property ( // [R6]
		@(posedge clk_in) disable iff (!rst_n_in)
		strap_taken_q && !low_mode_q |-> chain_pins_oe_out == 4'hf)
		else $error("chain pin released outside test");

	// Mode and entry checks.
	a_strap_hold: assert property ( // [R21]
		@(posedge clk_in) disable iff (!rst_n_in)
		strap_taken_q && $past(strap_taken_q) |-> $stable(low_mode_q))
		else $error("low mode changed after capture");
	a_code_order: assert property ( // [R20]
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(armed_q) |-> $past(state_q == XCBT_WAIT2, 1))
		else $error("armed without second code");
	a_code_first: assert property ( // [R20]
		@(posedge clk_in) disable iff (!rst_n_in)
		(state_q == XCBT_WAIT1 && strap_taken_q && code1_hit)
		|=> state_q == XCBT_WAIT2)
		else $error("first code missed");
	a_code_second: assert property ( // [R20]
		@(posedge clk_in) disable iff (!rst_n_in)
		(state_q == XCBT_WAIT2 && code2_hit) |=> armed_q)
		else $error("second code missed");
	a_code_restart: assert property ( // [R20]
		@(posedge clk_in) disable iff (!rst_n_in)
		(state_q == XCBT_WAIT2 && vclk_rise && !code1_hit && !code2_hit)
		|=> state_q == XCBT_WAIT1)
		else $error("wrong code did not restart entry");
	a_strap_high: assert property ( // [R10]
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(strap_taken_q) && mem_addr_bit2_pin_in |=> !armed_q)
		else $error("high chains armed without strap");

	// Scenario covers.
	c_low_mode: cover property (@(posedge clk_in) $rose(low_mode_q));
	c_armed: cover property (@(posedge clk_in) $rose(armed_q));
	c_toggle: cover property (@(posedge clk_in)
		low_mode_q && $changed(mem_addr_bit5_pin_out));
	c_restart: cover property (@(posedge clk_in)
		state_q == XCBT_WAIT2 && vclk_rise && !code2_hit);
	c_refused: cover property (@(posedge clk_in)
		state_q == XCBT_IDLE && strap_taken_q && code1_hit);
endmodule // xcbt_top
`default_nettype wire

// File: hdl/xcbt_pkg.sv
// Package with constants for the board test chain block.
package xcbt_pkg;
	localparam int XCBT_NUM_CHAINS = 8;
	localparam int XCBT_MAX_GATES = 64;
	localparam int XCBT_CH1_LEN = 35;
	localparam int XCBT_CH2_LEN = 33;
	localparam int XCBT_CH3_LEN = 38;
	localparam int XCBT_CH4_LEN = 36;
	localparam int XCBT_CH7_LEN = 33;
	localparam int XCBT_CH8_LEN = 31;
	localparam logic [5:0] XCBT_CODE_FIRST = 6'h2d;
	localparam logic [5:0] XCBT_CODE_SECOND = 6'h23;
	localparam logic XCBT_SEED = 1'h1;
	typedef enum logic [1:0] {
		XCBT_IDLE = 2'h0,
		XCBT_WAIT1 = 2'h1,
		XCBT_WAIT2 = 2'h3,
		XCBT_ARMED = 2'h2
	} xcbt_state_t;
endpackage

// File: hdl/xcbt_chain_if.sv
// Interface carrying the chain inputs and results between modules.
`timescale 1ns/1ps
`default_nettype none
interface xcbt_chain_if;
	logic [xcbt_pkg::XCBT_MAX_GATES-1:0] pins [xcbt_pkg::XCBT_NUM_CHAINS];
	logic [xcbt_pkg::XCBT_NUM_CHAINS-1:0] result;
	modport top (output pins, input result);
	modport tree (input pins, output result);
endinterface
`default_nettype wire

// File: hdl/xcbt_tree.sv
// Combinational chains of exclusive-or gates seeded with logic high.
`timescale 1ns/1ps
`default_nettype none
module xcbt_tree
	import xcbt_pkg::*;
(
	xcbt_chain_if.tree ch
);
	// Folds a chain gate by gate; unused positions are held low by the caller.
	function automatic logic chain_fold(input logic [XCBT_MAX_GATES-1:0] p);
		logic acc;
		acc = XCBT_SEED; // [R2]
		for (int i = 0; i < XCBT_MAX_GATES; i++) begin
			acc = acc ^ p[i]; // [R1]
		end
		return acc;
	endfunction

	// One independent result per chain, with no clock on the path.
	for (genvar c = 0; c < XCBT_NUM_CHAINS; c++) begin : g_chain
		assign ch.result[c] = chain_fold(ch.pins[c]); // [R4] [R5] [R13]
	end
endmodule // xcbt_tree
`default_nettype wire

// File: tb/xcbt_tester.sv
// Tester model that drives reset, the straps and the video code pins.
`timescale 1ns/1ps
`default_nettype none
module xcbt_tester (
	input wire logic clk_in,
	output logic rst_n_out,
	output logic row_strap_out,
	output logic a2_strap_out,
	output logic vclk_out,
	output logic [5:0] vdata_out
);
	// Power-up levels: reset asserted, straps high, video clock low.
	initial begin
		rst_n_out = 1'b0;
		row_strap_out = 1'b1;
		a2_strap_out = 1'b1;
		vclk_out = 1'b0;
		vdata_out = 6'h00;
	end
	// Reset goes high with the straps set, then pulses low for eight
	// cycles; the straps stay put through the pulse and after it.
	task automatic do_reset(input logic row, input logic a2);
		@(negedge clk_in);
		row_strap_out = row;
		a2_strap_out = a2;
		rst_n_out = 1'b1;
		@(negedge clk_in);
		rst_n_out = 1'b0;
		repeat (8) @(negedge clk_in);
		rst_n_out = 1'b1;
		repeat (3) @(negedge clk_in);
	endtask
	// Data is set with the clock low and held through the high phase.
	task automatic send_code(input logic [5:0] code);
		vdata_out = code;
		@(negedge clk_in);
		vclk_out = 1'b1;
		@(negedge clk_in);
		vclk_out = 1'b0;
		@(negedge clk_in);
		vdata_out = ~code; // Stale data is not left on the pins.
		@(negedge clk_in);
	endtask
endmodule // xcbt_tester
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the board test chain block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import xcbt_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n, row_strap, a2_strap, vclk;
	logic [5:0] vdata;
	logic [XCBT_CH1_LEN-1:0] ch1 = '0;
	logic [XCBT_CH2_LEN-1:0] ch2 = '0;
	logic [XCBT_CH3_LEN-1:0] ch3 = '0;
	logic [XCBT_CH4_LEN-1:0] ch4 = '0;
	logic [XCBT_CH7_LEN-1:0] ch7 = '0;
	logic [XCBT_CH8_LEN-1:0] ch8 = '0;
	logic [3:0] func = 4'h0;
	logic [3:0] oe;
	logic lo_mode, hi_mode, o5, o2, o0, o9, o8, o4;
	int bad_count = 0;
	int cmp_count = 0;
	// The clock runs at 10 MHz.
	always #50 clk_in = ~clk_in;
	xcbt_tester xcbt_tester_i (.clk_in(clk_in), .rst_n_out(rst_n),
		.row_strap_out(row_strap), .a2_strap_out(a2_strap),
		.vclk_out(vclk), .vdata_out(vdata));
	xcbt_top xcbt_top_i (.clk_in(clk_in), .rst_n_in(rst_n),
		.mem_row_strobe_pin_in(row_strap), .mem_addr_bit2_pin_in(a2_strap),
		.video_port_clock_pin_in(vclk), .video_port_data_pins_in(vdata),
		.chain1_pins_in(ch1), .chain2_pins_in(ch2), .chain3_pins_in(ch3),
		.chain4_pins_in(ch4), .chain7_pins_in(ch7), .chain8_pins_in(ch8),
		.func_addr_out_in(func), .chain_pins_oe_out(oe),
		.test_low_mode_out(lo_mode), .test_high_mode_out(hi_mode),
		.mem_addr_bit5_pin_out(o5), .mem_addr_bit2_pin_out(o2),
		.mem_addr_bit0_pin_out(o0), .mem_addr_bit9_pin_out(o9),
		.mem_addr_bit8_pin_out(o8), .mem_addr_bit4_pin_out(o4));
	// Compares one value with its expectation and counts the result.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Expected output when the lowest k pins of a chain of len are high.
	function automatic logic par(input int k, input int len);
		return (((k < len) ? k : len) % 2) == 0;
	endfunction
	// Expected output when all but the lowest k pins of a chain are high.
	function automatic logic ipar(input int k, input int len);
		return par(len - ((k < len) ? k : len), len);
	endfunction
	// Walks ones up every chain; the outputs follow the pins with no clock.
	// Chains 4 and 8 get the inverse walk, so a strobe and its partner at
	// one gate position always stand at opposite levels.
	task automatic walk(input logic hi);
		logic [63:0] m;
		for (int k = 0; k <= 40; k++) begin
			m = ~(64'hffff_ffff_ffff_ffff << k);
			ch1 = XCBT_CH1_LEN'(m);
			ch2 = XCBT_CH2_LEN'(m);
			ch3 = XCBT_CH3_LEN'(m);
			ch4 = XCBT_CH4_LEN'(~m);
			ch7 = XCBT_CH7_LEN'(m);
			ch8 = XCBT_CH8_LEN'(~m);
			repeat (2) @(negedge clk_in);
			chk(o5, par(k, XCBT_CH1_LEN));
			chk(o2, par(k, XCBT_CH2_LEN));
			chk(o0, par(k, XCBT_CH3_LEN));
			chk(o9, ipar(k, XCBT_CH4_LEN));
			chk(o8, hi & par(k, XCBT_CH7_LEN));
			chk(o4, hi & ipar(k, XCBT_CH8_LEN));
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic finish_test();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Main sequence: low mode, code entry with bad orders, then straps high.
	initial begin
		repeat (8) @(negedge clk_in);
		chk({oe, lo_mode, hi_mode, o5, o8}, 8'h00);
		xcbt_tester_i.do_reset(1'b0, 1'b0);
		chk({oe, lo_mode, hi_mode}, 6'h02);
		walk(1'b0);
		xcbt_tester_i.send_code(XCBT_CODE_SECOND);
		xcbt_tester_i.send_code(XCBT_CODE_FIRST);
		xcbt_tester_i.send_code(6'h00);
		xcbt_tester_i.send_code(XCBT_CODE_SECOND);
		chk(hi_mode, 1'b0);
		xcbt_tester_i.send_code(XCBT_CODE_FIRST);
		xcbt_tester_i.send_code(XCBT_CODE_SECOND);
		chk({lo_mode, hi_mode}, 2'h3);
		walk(1'b1);
		xcbt_tester_i.do_reset(1'b1, 1'b1);
		func = 4'hf;
		repeat (2) @(negedge clk_in);
		chk({oe, o5, o2, o0, o9}, 8'hff);
		chk(lo_mode, 1'b0);
		func = 4'h0;
		xcbt_tester_i.send_code(XCBT_CODE_FIRST);
		xcbt_tester_i.send_code(XCBT_CODE_SECOND);
		chk({lo_mode, hi_mode, o5, o2, o0, o9, o8}, 7'h00);
		finish_test();
	end
endmodule // tb
`default_nettype wire
